//--- verilog/twowire_pkg.sv
// Constants, field layout, status codes and phase type of the two-wire slave transmitter.
// Assumes a single 20 MHz system clock and a classic Wishbone register bus.
package twowire_pkg;

  // ==========================================================================
  // Register offsets (byte addresses).
  localparam logic [7:0] OFS_BYTE_BUFFER  = 8'h00;
  localparam logic [7:0] OFS_CONTROL      = 8'h04;
  localparam logic [7:0] OFS_STATE_REPORT = 8'h08;
  localparam logic [7:0] OFS_OWN_ADDRESS  = 8'h0C;

  // ==========================================================================
  // Control register fields.
  localparam int CTL_JOB_DONE = 7;
  localparam int CTL_ACK_EN   = 6;
  localparam int CTL_CLAIM    = 5;
  localparam int CTL_RELEASE  = 4;
  localparam int CTL_ENABLE   = 2;
  localparam logic [7:0] CTL_WRITABLE = 8'h74;

  // ==========================================================================
  // Reset values.
  localparam logic [7:0] CONTROL_RESET     = 8'h00;
  localparam logic [7:0] OWN_ADDRESS_RESET = 8'h00;
  localparam logic [7:0] BYTE_BUFFER_RESET = 8'hFF;
  localparam logic [7:0] STATUS_RESET      = 8'hF8;

  // ==========================================================================
  // Status codes.
  localparam logic [7:0] ST_OWN_READ  = 8'hA8;
  localparam logic [7:0] ST_ARB_READ  = 8'hB0;
  localparam logic [7:0] ST_DATA_ACK  = 8'hB8;
  localparam logic [7:0] ST_DATA_NACK = 8'hC0;
  localparam logic [7:0] ST_LAST_ACK  = 8'hC8;
  localparam logic [7:0] ST_NO_INFO   = 8'hF8;
  localparam logic [7:0] ST_BUS_ERROR = 8'h00;

  // ==========================================================================
  // Frame geometry.
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT  = 4'h7;
  localparam logic [6:0] BROADCAST_ADDRESS = 7'h00;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_ADDR,
    PH_ADDR_ACK,
    PH_TX,
    PH_TX_ACK,
    PH_WAIT,
    PH_ERROR
  } phase_t;

endpackage

//--- verilog/pin_sync.sv
// Two-flop synchronisers with edge detection for the bus clock and data lines.
// Assumes the pins are asynchronous to clk_i and idle high.
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Pins.
  input  wire logic [1:0] pin_i,
  // Synchronised levels and edges.
  output logic      [1:0] level_o,
  output logic      [1:0] rise_o,
  output logic      [1:0] fall_o
);

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] sync;
    logic [1:0] prev;
  } sync_t;

  sync_t s_q;
  sync_t s_d;

  // ==========================================================================
  // Next state.
  always_comb begin
    s_d      = s_q;
    s_d.meta = pin_i;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '{meta: 2'h3, sync: 2'h3, prev: 2'h3};
    end else begin
      s_q <= s_d;
    end
  end

  assign level_o = s_q.sync;
  assign rise_o  = s_q.sync & ~s_q.prev;
  assign fall_o  = ~s_q.sync & s_q.prev;

endmodule
`default_nettype wire

//--- verilog/twowire_slave_tx.sv
// Slave transmitter of the two-wire unit with its Wishbone register file.
// Assumes open-drain pins resolved outside and a master part that reports lost arbitration.
//
// Added by the designer: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module twowire_slave_tx (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Bus clock line.
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_o,
  // Bus data line.
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  // Master part.
  input  wire logic        arb_lost_i,
  output logic             claim_start_o,
  output logic             rx_handoff_o
);

  typedef struct packed {
    twowire_pkg::phase_t ph;
    logic [7:0]          shreg;
    logic [3:0]          bits;
    logic [7:0]          buffer;
    logic [7:0]          ctl;
    logic [7:0]          own;
    logic [7:0]          status;
    logic                last;
    logic                acked;
    logic                busy;
    logic                scl_hold;
    logic                sda_low;
    logic                claim;
    logic                handoff;
    logic                ack;
    logic [31:0]         rdata;
  } state_t;

  state_t     s_q;
  state_t     s_d;
  logic [1:0] lvl;
  logic [1:0] rise;
  logic [1:0] fall;

  // ==========================================================================
  // Pin synchronisers: bit 1 is the clock line, bit 0 the data line.
  pin_sync u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   ({scl_i, sda_i}),
    .level_o (lvl),
    .rise_o  (rise),
    .fall_o  (fall)
  );

  // ==========================================================================
  // Helpers.
  function automatic logic in_frame(input twowire_pkg::phase_t ph, input logic [3:0] bits);
    in_frame = (ph == twowire_pkg::PH_ADDR && bits != 4'h0) || ph == twowire_pkg::PH_ADDR_ACK ||
               ph == twowire_pkg::PH_TX || ph == twowire_pkg::PH_TX_ACK;
  endfunction

  function automatic logic is_final(input logic [7:0] code);
    is_final = code == twowire_pkg::ST_DATA_NACK || code == twowire_pkg::ST_LAST_ACK;
  endfunction

  logic scl_hi;
  logic start_seen;
  logic stop_seen;
  logic req;
  logic wr;
  logic sw_clear;
  logic own_hit;
  logic bc_hit;

  assign scl_hi     = lvl[1];
  assign start_seen = fall[0] & scl_hi;
  assign stop_seen  = rise[0] & scl_hi;
  assign req        = wb_cyc_i & wb_stb_i & ~s_q.ack;
  assign wr         = req & wb_we_i & wb_sel_i[0];
  assign sw_clear   = wr && wb_adr_i == twowire_pkg::OFS_CONTROL && wb_dat_i[twowire_pkg::CTL_JOB_DONE];
  assign own_hit    = s_q.shreg[7:1] == s_q.own[7:1];
  assign bc_hit     = s_q.shreg[7:1] == twowire_pkg::BROADCAST_ADDRESS && s_q.own[0];

  // ==========================================================================
  // Next state.
  always_comb begin
    s_d         = s_q;
    s_d.ack     = req;
    s_d.handoff = 1'b0;

    // Register reads.
    if (req) begin
      s_d.rdata = 32'h0000_0000;
      unique case (wb_adr_i)
        twowire_pkg::OFS_BYTE_BUFFER:  s_d.rdata[7:0] = s_q.buffer;
        twowire_pkg::OFS_CONTROL:      s_d.rdata[7:0] = s_q.ctl;
        twowire_pkg::OFS_STATE_REPORT: s_d.rdata[7:0] = s_q.ctl[twowire_pkg::CTL_JOB_DONE] ?
                                                         s_q.status : twowire_pkg::ST_NO_INFO;
        twowire_pkg::OFS_OWN_ADDRESS:  s_d.rdata[7:0] = s_q.own;
        default:                       s_d.rdata = 32'h0000_0000;
      endcase
    end

    // Register writes.
    if (wr) begin
      unique case (wb_adr_i)
        twowire_pkg::OFS_BYTE_BUFFER: s_d.buffer = wb_dat_i[7:0];
        twowire_pkg::OFS_OWN_ADDRESS: s_d.own = wb_dat_i[7:0];
        twowire_pkg::OFS_CONTROL: begin
          s_d.ctl = wb_dat_i[7:0] & twowire_pkg::CTL_WRITABLE;
          s_d.ctl[twowire_pkg::CTL_JOB_DONE] = s_q.ctl[twowire_pkg::CTL_JOB_DONE] & ~sw_clear;
        end
        default: s_d.buffer = s_d.buffer;
      endcase
    end

    // Bus occupancy.
    if (start_seen) begin
      s_d.busy = 1'b1;
    end else if (stop_seen) begin
      s_d.busy = 1'b0;
    end

    // Transfer sequencing.
    if (!s_q.ctl[twowire_pkg::CTL_ENABLE]) begin
      s_d.ph       = twowire_pkg::PH_IDLE;
      s_d.scl_hold = 1'b0;
      s_d.sda_low  = 1'b0;
    end else if ((start_seen || stop_seen) && in_frame(s_q.ph, s_q.bits)) begin
      s_d.ph       = twowire_pkg::PH_ERROR;
      s_d.scl_hold = 1'b0;
      s_d.sda_low  = 1'b0;
      s_d.status   = twowire_pkg::ST_BUS_ERROR;
      s_d.ctl[twowire_pkg::CTL_JOB_DONE] = 1'b1;
    end else begin
      unique case (s_q.ph)
        twowire_pkg::PH_IDLE: begin
          if (start_seen && s_q.ctl[twowire_pkg::CTL_ACK_EN]) begin
            s_d.ph   = twowire_pkg::PH_ADDR;
            s_d.bits = 4'h0;
          end
        end
        twowire_pkg::PH_ADDR: begin
          if (start_seen) begin
            s_d.bits = 4'h0;
          end else if (stop_seen) begin
            s_d.ph = twowire_pkg::PH_IDLE;
          end else if (rise[1] && s_q.bits != twowire_pkg::BYTE_BITS) begin
            s_d.shreg = {s_q.shreg[6:0], lvl[0]};
            s_d.bits  = s_q.bits + 4'h1;
          end else if (fall[1] && s_q.bits == twowire_pkg::BYTE_BITS) begin
            s_d.ph = twowire_pkg::PH_IDLE;
            if (own_hit && s_q.shreg[0]) begin
              s_d.ph      = twowire_pkg::PH_ADDR_ACK;
              s_d.sda_low = 1'b1;
            end else if ((own_hit || bc_hit) && !s_q.shreg[0]) begin
              s_d.handoff = 1'b1;
            end
          end
        end
        twowire_pkg::PH_ADDR_ACK: begin
          if (fall[1]) begin
            s_d.ph       = twowire_pkg::PH_WAIT;
            s_d.sda_low  = 1'b0;
            s_d.scl_hold = 1'b1;
            s_d.status   = arb_lost_i ? twowire_pkg::ST_ARB_READ : twowire_pkg::ST_OWN_READ;
            s_d.ctl[twowire_pkg::CTL_JOB_DONE] = 1'b1;
          end
        end
        twowire_pkg::PH_WAIT: begin
          if (sw_clear) begin
            s_d.scl_hold = 1'b0;
            if (is_final(s_q.status)) begin
              s_d.ph = twowire_pkg::PH_IDLE;
            end else begin
              s_d.ph      = twowire_pkg::PH_TX;
              s_d.shreg   = s_d.buffer;
              s_d.bits    = 4'h0;
              s_d.sda_low = ~s_d.buffer[7];
              s_d.last    = ~wb_dat_i[twowire_pkg::CTL_ACK_EN];
            end
          end
        end
        twowire_pkg::PH_TX: begin
          if (fall[1]) begin
            if (s_q.bits == twowire_pkg::LAST_BIT) begin
              s_d.ph      = twowire_pkg::PH_TX_ACK;
              s_d.sda_low = 1'b0;
            end else begin
              s_d.shreg   = {s_q.shreg[6:0], 1'b1};
              s_d.sda_low = ~s_q.shreg[6];
            end
            s_d.bits = s_q.bits + 4'h1;
          end
        end
        twowire_pkg::PH_TX_ACK: begin
          if (rise[1]) begin
            s_d.acked = ~lvl[0];
          end else if (fall[1]) begin
            s_d.ph       = twowire_pkg::PH_WAIT;
            s_d.scl_hold = 1'b1;
            s_d.ctl[twowire_pkg::CTL_JOB_DONE] = 1'b1;
            if (!s_q.acked) begin
              s_d.status = twowire_pkg::ST_DATA_NACK;
            end else if (s_q.last) begin
              s_d.status = twowire_pkg::ST_LAST_ACK;
            end else begin
              s_d.status = twowire_pkg::ST_DATA_ACK;
            end
          end
        end
        twowire_pkg::PH_ERROR: begin
          s_d.scl_hold = 1'b0;
          s_d.sda_low  = 1'b0;
          if (sw_clear && wb_dat_i[twowire_pkg::CTL_RELEASE]) begin
            s_d.ph = twowire_pkg::PH_IDLE;
            s_d.ctl[twowire_pkg::CTL_RELEASE] = 1'b0;
          end
        end
        default: s_d.ph = twowire_pkg::PH_IDLE;
      endcase
    end

    // Start request toward the master part once the bus is free.
    s_d.claim = s_d.ctl[twowire_pkg::CTL_CLAIM] && s_d.ctl[twowire_pkg::CTL_ENABLE] &&
                !s_d.busy && s_d.ph == twowire_pkg::PH_IDLE;
  end

  // ==========================================================================
  // State register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '{ph: twowire_pkg::PH_IDLE, shreg: 8'h00, bits: 4'h0,
               buffer: twowire_pkg::BYTE_BUFFER_RESET, ctl: twowire_pkg::CONTROL_RESET,
               own: twowire_pkg::OWN_ADDRESS_RESET, status: twowire_pkg::STATUS_RESET,
               last: 1'b0, acked: 1'b0, busy: 1'b0, scl_hold: 1'b0, sda_low: 1'b0,
               claim: 1'b0, handoff: 1'b0, ack: 1'b0, rdata: 32'h0000_0000};
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs.
  assign wb_dat_o      = s_q.rdata;
  assign wb_ack_o      = s_q.ack;
  assign scl_o         = 1'b0;
  assign scl_oe_o      = s_q.scl_hold;
  assign sda_o         = 1'b0;
  assign sda_oe_o      = s_q.sda_low;
  assign claim_start_o = s_q.claim;
  assign rx_handoff_o  = s_q.handoff;

endmodule
`default_nettype wire

//--- tb/twowire_master_rx_model.sv
// Behavioural two-wire master receiver facing the slave transmitter.
// Assumes pull-ups on both lines, resolved by the bench from all drives.
`timescale 1ns/1ps
`default_nettype none
module twowire_master_rx_model (
  // Resolved lines.
  input  wire logic scl_i,
  input  wire logic sda_i,
  // Drives, low pulls the line.
  output var logic  scl_o,
  output var logic  sda_o
);
  // ==================================================
  // Conditions and bit transfer.
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic bit_io(input logic b, output logic s);
    #50 sda_o = b;
    #($urandom_range(300, 150)) scl_o = 1'b1;
    wait (scl_i === 1'b1);
    #200 s = sda_i;
    scl_o = 1'b0;
  endtask
  task automatic cond(input logic stop);
    #50 sda_o = ~stop;
    #150 scl_o = 1'b1;
    wait (scl_i === 1'b1);
    #200 sda_o = ~sda_o;
    #200 scl_o = stop;
  endtask
  task automatic send(input logic [7:0] v, input int n, output logic ack);
    for (int i = 7; i > 7 - n; i--)
      bit_io(v[i], ack);
    if (n == 8)
      bit_io(1'b1, ack);
  endtask
  task automatic read(input logic ack, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, v[i]);
    bit_io(~ack, s);
  endtask
endmodule
`default_nettype wire

//--- tb/twowire_slave_tx_properties.sv
// Concurrent checks on the ports of the two-wire slave transmitter.
// Assumes the bench resolves both bus lines onto scl_i and sda_i.
`timescale 1ns/1ps
`default_nettype none
module twowire_slave_tx_properties (
  // Clock and reset.
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Register bus.
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Bus lines and master part.
  input wire logic        scl_i,
  input wire logic        scl_o,
  input wire logic        scl_oe_o,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_o,
  input wire logic        arb_lost_i,
  input wire logic        claim_start_o,
  input wire logic        rx_handoff_o
);
  // ==================================================
  // Assertions.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic clr = req && wb_we_i && wb_sel_i[0] && wb_adr_i == twowire_pkg::OFS_CONTROL && wb_dat_i[7];
  wire logic rec = clr && wb_dat_i[4];
  AST_WB_ACK: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Ack is not one pulse after the request.");
  AST_WB_UPPER: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("Upper read data not zero.");
  AST_HOLD_STRETCH: assert property (scl_oe_o && !clr |=> scl_oe_o)
    else $error("Clock stretch ended without a flag clear.");
  AST_FREE_STRETCH: assert property (scl_oe_o && clr |=> !scl_oe_o)
    else $error("Clock stretch kept after a flag clear.");
  AST_STRETCH_LOW: assert property ($rose(scl_oe_o) |-> !scl_i)
    else $error("Stretch began while the clock was high.");
  AST_SDA_LOW: assert property ($rose(sda_oe_o) |-> !scl_i || $fell(scl_oe_o))
    else $error("Data pulled low while the clock was high.");
  AST_RECOVER: assert property (rec |=> (!scl_oe_o && !sda_oe_o)[*2])
    else $error("Lines not released on recovery.");
  AST_CLAIM: assert property ($rose(claim_start_o) |-> scl_i && sda_i)
    else $error("Start request while the bus is busy.");
  AST_HANDOFF: assert property (rx_handoff_o |=> !rx_handoff_o)
    else $error("Handoff longer than one cycle.");
  cover property ($rose(scl_oe_o));
  cover property (rec);
  cover property ($rose(claim_start_o));
endmodule
bind twowire_slave_tx twowire_slave_tx_properties i_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .scl_i, .scl_o, .scl_oe_o, .sda_i, .sda_o, .sda_oe_o,
  .arb_lost_i, .claim_start_o, .rx_handoff_o);
`default_nettype wire

//--- tb/twowire_slave_tx_bench.sv
// Self-checking bench of the two-wire slave transmitter with a master receiver model.
// Assumes pull-ups on both lines and a 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module twowire_slave_tx_bench;
  localparam logic [7:0] BUF = twowire_pkg::OFS_BYTE_BUFFER;
  localparam logic [7:0] CTL = twowire_pkg::OFS_CONTROL;
  localparam logic [7:0] STS = twowire_pkg::OFS_STATE_REPORT;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0, arb_lost_i = 1'b0, m_scl, m_sda;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [6:0]  own;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
  logic [3:0]  wb_sel_i = 4'h0;
  logic        wb_ack_o, scl_o, scl_oe_o, sda_o, sda_oe_o, claim_start_o, rx_handoff_o;
  wire logic   scl_i = m_scl & (scl_o | ~scl_oe_o);
  wire logic   sda_i = m_sda & (sda_o | ~sda_oe_o);
  int          bad_count = 0, checks_done = 0, hand_n = 0;
  // ==================================================
  // Harness and shared tasks.
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i)
    hand_n += (rx_handoff_o === 1'b1);
  twowire_slave_tx i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
    .wb_dat_o, .wb_ack_o, .scl_i, .scl_o, .scl_oe_o, .sda_i, .sda_o, .sda_oe_o, .arb_lost_i,
    .claim_start_o, .rx_handoff_o);
  twowire_master_rx_model i_master (.scl_i, .sda_i, .scl_o(m_scl), .sda_o(m_sda));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'($urandom), dat};
    wb_sel_i <= {3'($urandom), 1'b1};
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && ++n < 20);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    chk({7'h00, wb_ack_o}, 8'h01);
  endtask
  task automatic rdc(input logic [7:0] adr, input logic [7:0] exp);
    logic [7:0] v;
    wb(1'b0, adr, 8'h00, v);
    chk(v, exp);
  endtask
  task automatic wflag();
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < 80 && v[7] !== 1'b1; i++)
      wb(1'b0, CTL, 8'h00, v);
  endtask
  task automatic xfer(input int t);
    logic       a;
    logic [7:0] d, got, v;
    int         nb;
    nb = $urandom_range(3, 1);
    @(posedge clk_i);
    arb_lost_i <= (t == 1);
    i_master.cond(1'b0);
    i_master.send({own, 1'b1}, 8, a);
    chk({7'h00, a}, 8'h00);
    wflag();
    rdc(STS, t == 1 ? twowire_pkg::ST_ARB_READ : twowire_pkg::ST_OWN_READ);
    for (int i = 0; i < nb; i++) begin
      d = 8'($urandom);
      wb(1'b1, BUF, d, v);
      wb(1'b1, CTL, i < nb - 1 ? 8'hC4 : 8'h84, v);
      rdc(STS, twowire_pkg::ST_NO_INFO);
      i_master.read(i < nb - 1 || t == 1, got);
      chk(got, d);
      wflag();
      rdc(STS, i < nb - 1 ? 8'hB8 : t == 1 ? 8'hC8 : 8'hC0);
    end
    wb(1'b1, CTL, t == 0 ? 8'h84 : t == 2 ? 8'hE4 : 8'hC4, v);
    if (t == 1) begin
      i_master.read(1'b0, got);
      chk(got, 8'hFF);
    end
    i_master.cond(1'b1);
    if (t < 2) begin
      i_master.cond(1'b0);
      i_master.send(t == 0 ? {own, 1'b1} : 8'h00, 8, a);
      chk({7'h00, a}, 8'h01);
      i_master.cond(1'b1);
    end
    for (int n = 0; n < 20 && t == 2 && claim_start_o !== 1'b1; n++)
      @(posedge clk_i);
    @(posedge clk_i);
    chk({7'h00, claim_start_o}, {7'h00, t == 2});
    arb_lost_i <= 1'b0;
    wb(1'b1, CTL, 8'h44, v);
  endtask
  // ==================================================
  // Main sequence and watchdog.
  initial begin
    logic [7:0] v;
    logic       a;
    void'($urandom(44));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rdc(BUF, twowire_pkg::BYTE_BUFFER_RESET);
    rdc(CTL, twowire_pkg::CONTROL_RESET);
    rdc(twowire_pkg::OFS_OWN_ADDRESS, twowire_pkg::OWN_ADDRESS_RESET);
    rdc(STS, twowire_pkg::ST_NO_INFO);
    rdc(8'h10, 8'h00);
    own = 7'($urandom_range(126, 1));
    wb(1'b1, twowire_pkg::OFS_OWN_ADDRESS, {own, 1'b1}, v);
    rdc(twowire_pkg::OFS_OWN_ADDRESS, {own, 1'b1});
    wb(1'b1, CTL, 8'h44, v);
    for (int t = 0; t < 3; t++)
      xfer(t);
    i_master.cond(1'b0);
    i_master.send({own, 1'b1}, 3, a);
    i_master.cond(1'b0);
    wflag();
    rdc(STS, twowire_pkg::ST_BUS_ERROR);
    chk({6'h00, scl_oe_o, sda_oe_o}, 8'h00);
    chk({6'h00, scl_o, sda_o}, 8'h00);
    wb(1'b1, CTL, 8'hD4, v);
    rdc(CTL, 8'h44);
    rdc(STS, twowire_pkg::ST_NO_INFO);
    i_master.cond(1'b1);
    xfer(3);
    chk(8'(hand_n), 8'h01);
    close_out();
  end
  initial begin
    #2ms;
    bad_count++;
    close_out();
  end
endmodule
`default_nettype wire
